/* File: bench/icnt_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far side: comb stage feeding samples, summation block taking words
module icnt_far_model (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic stall,
    input wire logic [15:0] src_i,
    input wire logic [15:0] src_q,
    input wire integer limit,
    output logic in_valid,
    input wire logic in_ready,
    output icnt_pkg::icnt_iq_t in_sample,
    input wire logic out_valid,
    output logic out_ready,
    input wire icnt_pkg::icnt_word_t out_word,
    output int sent,
    output int n_words,
    output int n_q,
    output int n_bad,
    output logic signed [17:0] last_i
);
    import icnt_pkg::*;
    logic prev_q;
    int cyc = 0;
    // Quiet lines at time zero
    initial begin
        in_valid = 1'b0;
        in_sample = '0;
        out_ready = 1'b0;
    end
    // Sample held until taken; idle data inverted so nothing stale passes
    always @(negedge core_clk) begin
        cyc <= cyc + 1;
        in_valid <= reset_n && (sent < limit);
        in_sample <= (sent < limit) ? {src_i, src_q} : ~{src_i, src_q};
        out_ready <= !stall || (cyc % 3 == 0); // Slow sink fills the buffer
    end
    // Count accepted samples and delivered words
    always @(posedge core_clk) begin
        if (!reset_n) begin
            sent <= 0;
            n_words <= 0;
            n_q <= 0;
            n_bad <= 0;
            prev_q <= 1'b1;
            last_i <= '0;
        end else begin
            if (in_valid && in_ready)
                sent <= sent + 1;
            if (out_valid && out_ready) begin
                n_words <= n_words + 1;
                n_q <= n_q + int'(out_word.is_q);
                prev_q <= out_word.is_q;
                if (out_word.is_q && prev_q)
                    n_bad <= n_bad + 1; // Q must follow its I
                if (!out_word.is_q)
                    last_i <= out_word.data;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import icnt_pkg::*;
    logic core_clk, reset_n, sync_pin, sum_complex, stall;
    logic in_valid, in_ready, out_valid, out_ready;
    logic [31:0] cfg_rdata;
    logic [15:0] src_i, src_q;
    logic signed [17:0] last_i;
    icnt_cfg_t cfg;
    icnt_iq_t in_sample;
    icnt_word_t out_word;
    int limit, sent, n_words, n_q, n_bad, err_count, checks, w0, q0, mag0;
    int mag1;
    logic [7:0] ra[5] = '{ADDR_CTRL, ADDR_FREQ, ADDR_POFF, ADDR_FACTOR, 8'h03};
    logic [31:0] rm[5] = '{32'h1F, 32'hFFFF_FFFF, 32'hFFFF, 32'hFF, 32'h0};

    icnt_tuner dut_u (.core_clk(core_clk), .reset_n(reset_n), .cfg(cfg),
        .cfg_rdata(cfg_rdata), .sync_pin(sync_pin),
        .sum_complex(sum_complex), .in_valid(in_valid), .in_ready(in_ready),
        .in_sample(in_sample), .out_valid(out_valid), .out_ready(out_ready),
        .out_word(out_word));
    icnt_far_model far_u (.core_clk(core_clk), .reset_n(reset_n),
        .stall(stall), .src_i(src_i), .src_q(src_q), .limit(limit),
        .in_valid(in_valid), .in_ready(in_ready), .in_sample(in_sample),
        .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word),
        .sent(sent), .n_words(n_words), .n_q(n_q), .n_bad(n_bad),
        .last_i(last_i));

    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobe held for exactly one edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge core_clk);
        cfg <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge core_clk);
        cfg.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge core_clk);
        cfg <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(negedge core_clk);
        cfg.rd <= 1'b0;
        @(negedge core_clk);
        chk(cfg_rdata, exp);
    endtask

    // Release n samples, wait for the words owed, then check none extra
    task automatic burst(input int n, input int per);
        int t;
        w0 = n_words;
        q0 = n_q;
        @(negedge core_clk);
        limit <= limit + n;
        for (t = 0; t < 20000 && n_words - w0 < n * per; t++)
            @(negedge core_clk);
        repeat (40) @(negedge core_clk);
        chk(n_words - w0, n * per);
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        #200000;
        err_count++;
        conclude();
    end

    initial begin
        reset_n = 1'b0;
        sync_pin = 1'b0;
        sum_complex = 1'b0;
        stall = 1'b1;
        cfg = '0;
        src_i = 16'h6000;
        src_q = 16'h0000;
        limit = 0;
        err_count = 0;
        checks = 0;
        repeat (20) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge core_clk);
        // Reset values, full-width writes, unmapped place reads zero
        for (int k = 0; k < 5; k++) begin
            rd(ra[k], 32'h0);
            wr(ra[k], 32'hFFFF_FFFF);
            rd(ra[k], rm[k]);
        end
        // Real mode, L of 4, still oscillator at angle zero
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_FREQ, 32'h0);
        wr(ADDR_POFF, 32'h0);
        wr(ADDR_FACTOR, 32'h3);
        burst(6, 4);
        chk(n_q - q0, 0);
        mag0 = int'(last_i);
        chk(mag0 > 0, 1);
        // Half-turn offset inverts the carrier
        wr(ADDR_POFF, 32'h8000);
        burst(6, 4);
        chk(last_i < 0, 1);
        // Each scale step halves the carrier
        wr(ADDR_POFF, 32'h0);
        for (int s = 1; s < 3; s++) begin
            wr(ADDR_CTRL, s);
            burst(3, 4);
            chk(last_i, mag0 >> s);
        end
        // Deepest attenuation with both dithers on
        wr(ADDR_CTRL, 32'h1B);
        burst(6, 4);
        mag1 = last_i < 0 ? -int'(last_i) : int'(last_i);
        chk(4 * mag1 < mag0, 1);
        // Complex mode: I then Q for every slot
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_FACTOR, 32'h0);
        wr(ADDR_FREQ, 32'h1000_0000);
        sum_complex = 1'b1;
        burst(5, 2);
        chk(n_q - q0, 5);
        chk(n_bad, 0);
        // Largest factor, L of 256
        sum_complex = 1'b0;
        wr(ADDR_FACTOR, 32'hFF);
        burst(2, 256);
        // Phase left off zero; frozen oscillator, then sync clears it
        wr(ADDR_FREQ, 32'h0);
        wr(ADDR_FACTOR, 32'h3);
        wr(ADDR_CTRL, 32'h4);
        sync_pin = 1'b1;
        repeat (4) @(negedge core_clk);
        sync_pin = 1'b0;
        burst(2, 4);
        chk(last_i, mag0);
        conclude();
    end
endmodule
`default_nettype wire

/* File: common/icnt_pkg.sv */
package icnt_pkg;
    // Channel register locations
    localparam logic [7:0] ADDR_CTRL = 8'h01;
    localparam logic [7:0] ADDR_FREQ = 8'h02;
    localparam logic [7:0] ADDR_POFF = 8'h04;
    localparam logic [7:0] ADDR_FACTOR = 8'h08;
    // Control register field positions
    localparam int CTRL_SCALE_LO = 0;
    localparam int CTRL_PCLR = 2;
    localparam int CTRL_PDITH = 3;
    localparam int CTRL_ADITH = 4;
    localparam int CTRL_W = 5;
    // Values after reset
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [31:0] FREQ_RST = 32'h0000_0000;
    localparam logic [15:0] POFF_RST = 16'h0000;
    localparam logic [7:0] FACTOR_RST = 8'h00;
    localparam logic [31:0] LFSR_SEED = 32'hACE1_2345;
    localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;
    // Oscillator and mixer shaping
    localparam int PHASE_W = 18;
    localparam int PHASE_LSB = 32 - PHASE_W;
    localparam logic [17:0] QUARTER_TURN = 18'h10000;
    localparam int MIX_SHIFT_BASE = 17;
    localparam int AMP_DITH_W = 6;
    localparam int CIC_W = 26;
    localparam int CIC_OUT_W = 24;

    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } icnt_iq_t;

    typedef struct packed {
        logic signed [17:0] data;
        logic is_q;
    } icnt_word_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } icnt_cfg_t;

    typedef enum logic {
        SLOT_I = 1'b0,
        SLOT_Q = 1'b1
    } icnt_slot_t;
endpackage

/* File: hdl/icnt_pair_buf.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer; entry 0 is the output register itself
module icnt_pair_buf (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire icnt_pkg::icnt_word_t in_word,
    output logic out_valid,
    input wire logic out_ready,
    output icnt_pkg::icnt_word_t out_word
);
    import icnt_pkg::*;

    logic full;
    icnt_word_t spare;
    wire pop = out_valid & out_ready;
    wire push = in_valid & ~full;

    // Ready is the inverse of a flop, so the source sees no comb path
    assign in_ready = ~full;

    // Shift structure keeps outputs straight from flops
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            out_valid <= 1'b0;
            full <= 1'b0;
            out_word <= '0;
            spare <= '0;
        end else if (pop) begin
            out_valid <= full | push;
            out_word <= full ? spare : in_word;
            full <= full & push;
            if (full & push) begin
                spare <= in_word;
            end
        end else if (!out_valid) begin
            out_valid <= push;
            out_word <= in_word;
        end else if (!full) begin
            full <= push;
            spare <= in_word;
        end
    end

    AST_NO_LOSS: assert property (@(posedge core_clk) disable iff (!reset_n)
        full && !out_ready |=> full && $stable(out_word))
        else $error("held word changed while stalled");
endmodule
`default_nettype wire

/* File: hdl/icnt_tuner.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RULE1) Interpolation factor minus one comes from 8-bit location 0x08.
// (RULE2) Comb interpolator is a squared length-L moving sum, baseband gain L.
// (RULE3) Software keeps the factor within the second-order stage limits.
// (RULE4) Tuner holds a 32-bit quadrature oscillator and a quadrature mixer.
// (RULE5) Real or complex mixed words go out as the summation block asks.
// (RULE6) Complex mode: oscillator advances at half the clock rate.
// (RULE7) Real mode: oscillator advances every clock, only in-phase goes out; the code advances every other clock when L is 1.
// (RULE8) IF equals oscillator rate times frequency word over two to 32.
// (RULE9) Only the top 18 accumulator bits reach the sine conversion.
// (RULE10) Control bit 3 adds random phase below the truncation point.
// (RULE11) Control bit 4 adds random amplitude before mixer truncation.
// (RULE12) 16-bit phase offset at 0x04 adds to the oscillator phase.
// (RULE13) Accumulator adds the frequency word per update, wrapping freely.
// (RULE14) Control bits 1..0 attenuate output by 0, 6, 12 or 18 dB.
// (RULE15) With control bit 2 set, a sync event clears the phase.
module icnt_tuner (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire icnt_pkg::icnt_cfg_t cfg,
    output logic [31:0] cfg_rdata,
    input wire logic sync_pin,
    input wire logic sum_complex,
    input wire logic in_valid,
    output logic in_ready,
    input wire icnt_pkg::icnt_iq_t in_sample,
    output logic out_valid,
    input wire logic out_ready,
    output icnt_pkg::icnt_word_t out_word
);
    import icnt_pkg::*;

    logic [CTRL_W-1:0] ctrl;
    logic [31:0] freq;
    logic [15:0] poff;
    logic [7:0] factor;
    logic [31:0] acc;
    logic [31:0] lfsr;
    logic sync_m, sync_s, sync_d;
    icnt_iq_t hold;
    logic hold_v;
    icnt_iq_t prev_x;
    logic signed [16:0] prev_c1_i, prev_c1_q;
    logic signed [CIC_W-1:0] int1_i, int1_q, int2_i, int2_q;
    logic [7:0] k;
    icnt_slot_t slot;
    logic signed [17:0] q_held;
    logic buf_ready;

    // Register decode
    wire wr_ctrl = cfg.wr && cfg.addr == ADDR_CTRL;
    wire wr_freq = cfg.wr && cfg.addr == ADDR_FREQ;
    wire wr_poff = cfg.wr && cfg.addr == ADDR_POFF;
    wire wr_factor = cfg.wr && cfg.addr == ADDR_FACTOR;
    wire [31:0] rd_mux =
        cfg.addr == ADDR_CTRL ? {27'h0, ctrl} :
        cfg.addr == ADDR_FREQ ? freq :
        cfg.addr == ADDR_POFF ? {16'h0, poff} :
        cfg.addr == ADDR_FACTOR ? {24'h0, factor} : 32'h0;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl <= CTRL_RST;
            freq <= FREQ_RST;
            poff <= POFF_RST;
            factor <= FACTOR_RST;
            cfg_rdata <= 32'h0;
        end else begin
            if (wr_ctrl) ctrl <= cfg.wdata[CTRL_W-1:0];
            if (wr_freq) freq <= cfg.wdata; // see RULE8
            if (wr_poff) poff <= cfg.wdata[15:0]; // see RULE12
            if (wr_factor) factor <= cfg.wdata[7:0]; // see RULE1
            if (cfg.rd) cfg_rdata <= rd_mux;
        end
    end

    // Sync pin: two flops, then edge taken from the second and third
    wire sync_evt = sync_s & ~sync_d;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sync_m <= 1'b0;
            sync_s <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            sync_m <= sync_pin;
            sync_s <= sync_m;
            sync_d <= sync_s;
        end
    end

    // Slot scheduling; a new input is needed only at the start of a burst
    wire cplx = sum_complex;
    wire fire_a = slot == SLOT_I && buf_ready && (k != 8'h00 || hold_v);
    wire fire_b = slot == SLOT_Q && buf_ready;
    wire take_in = fire_a && k == 8'h00; // see RULE2
    wire accept = in_valid & in_ready;
    wire [7:0] next_k = (k == factor) ? 8'h00 : k + 8'h01; // see RULE1
    wire next_hold_v = accept | (hold_v & ~take_in);

    // Input holding register: ready is a flop, one word per two cycles
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            hold <= '0;
            hold_v <= 1'b0;
            in_ready <= 1'b0;
        end else begin
            if (accept) hold <= in_sample;
            hold_v <= next_hold_v;
            in_ready <= ~next_hold_v;
        end
    end

    // Combs at the input rate, zero stuffing, integrators at output rate
    wire signed [16:0] c1_i = 17'(hold.i) - 17'(prev_x.i);
    wire signed [16:0] c1_q = 17'(hold.q) - 17'(prev_x.q);
    wire signed [17:0] c2_i = 18'(c1_i) - 18'(prev_c1_i);
    wire signed [17:0] c2_q = 18'(c1_q) - 18'(prev_c1_q);
    wire signed [CIC_W-1:0] u_i = take_in ? CIC_W'(c2_i) : '0;
    wire signed [CIC_W-1:0] u_q = take_in ? CIC_W'(c2_q) : '0;

    // Integrators wrap on purpose; the output still fits for legal factors
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            prev_x <= '0;
            prev_c1_i <= '0;
            prev_c1_q <= '0;
            int1_i <= '0;
            int1_q <= '0;
            int2_i <= '0;
            int2_q <= '0;
            k <= 8'h00;
        end else if (fire_a) begin
            if (take_in) begin
                prev_x <= hold;
                prev_c1_i <= c1_i;
                prev_c1_q <= c1_q;
            end
            int1_i <= int1_i + u_i; // see RULE2
            int1_q <= int1_q + u_q;
            int2_i <= int2_i + int1_i;
            int2_q <= int2_q + int1_q;
            k <= next_k;
        end
    end

    // Free-running noise source for both dither kinds
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lfsr <= LFSR_SEED;
        end else begin
            lfsr <= {lfsr[30:0], ^(lfsr & LFSR_TAPS)};
        end
    end

    // Oscillator phase: offset in the top half, dither below the cut
    wire [31:0] pdith = ctrl[CTRL_PDITH] ?
        {18'h0, lfsr[PHASE_LSB-1:0]} : 32'h0; // see RULE10
    wire [31:0] phase_full = acc + {poff, 16'h0} + pdith; // see RULE12
    wire [17:0] ph18 = phase_full[31:PHASE_LSB]; // see RULE9
    wire clear_phase = sync_evt && ctrl[CTRL_PCLR];

    // Advances once per slot: every clock real (every other clock when L is 1), every other clock complex
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            acc <= 32'h0;
        end else if (clear_phase) begin
            acc <= 32'h0; // see RULE15
        end else if (fire_a) begin // see RULE6 RULE7
            acc <= acc + freq; // see RULE13
        end
    end

    // Parabolic sine; cheap, trades some spur level for no table
    function automatic logic signed [17:0] icnt_sine(input logic [17:0] ph);
        logic [16:0] x;
        logic [34:0] p;
        logic [17:0] m;
        x = ph[16:0];
        p = {18'h0, x} * (35'h20000 - {18'h0, x});
        m = {1'b0, p[33:17]};
        return ph[17] ? -$signed(m) : $signed(m);
    endfunction

    wire signed [17:0] sin_v = icnt_sine(ph18);
    wire signed [17:0] cos_v = icnt_sine(ph18 + QUARTER_TURN);

    // Amplitude dither lands below the bits the mixer keeps
    wire [AMP_DITH_W-1:0] adith = ctrl[CTRL_ADITH] ?
        lfsr[31:26] : '0; // see RULE11
    wire signed [24:0] mx_i = 25'(int2_i[CIC_OUT_W-1:0]) + 25'(adith);
    wire signed [24:0] mx_q = 25'(int2_q[CIC_OUT_W-1:0]) + 25'(adith);
    wire signed [17:0] x_i = mx_i[23:6];
    wire signed [17:0] x_q = mx_q[23:6];

    // Quadrature mixer and output attenuation
    wire signed [36:0] prod_i = 37'(x_i * cos_v) - 37'(x_q * sin_v);
    wire signed [36:0] prod_q = 37'(x_i * sin_v) + 37'(x_q * cos_v);
    wire [5:0] shift = 6'(MIX_SHIFT_BASE) + 6'(ctrl[1:CTRL_SCALE_LO]);
    wire signed [36:0] sh_i = prod_i >>> shift; // see RULE14
    wire signed [36:0] sh_q = prod_q >>> shift;

    // Word offered to the buffer; Q part dropped in real mode
    wire push = fire_a | fire_b;
    icnt_word_t push_word;
    assign push_word.data = fire_b ? q_held : sh_i[17:0]; // see RULE4
    assign push_word.is_q = fire_b;

    // Complex mode spends a second clock on the held Q word
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            slot <= SLOT_I;
            q_held <= '0;
        end else if (fire_a && cplx) begin
            slot <= SLOT_Q; // see RULE6
            q_held <= sh_q[17:0];
        end else if (fire_b) begin
            slot <= SLOT_I; // see RULE5
        end
    end

    icnt_pair_buf u_buf (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .in_valid(push),
        .in_ready(buf_ready),
        .in_word(push_word),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_word(out_word)
    );

    AST_FACTOR_LOAD: assert property ( // see RULE1
        @(posedge core_clk) disable iff (!reset_n)
        wr_factor |=> factor == $past(cfg.wdata[7:0]))
        else $error("factor not loaded");
    AST_BURST_LEN: assert property ( // see RULE2
        @(posedge core_clk) disable iff (!reset_n)
        fire_a && k == factor |=> k == 8'h00)
        else $error("burst did not end at factor");
    AST_TAKE_ONLY_K0: assert property ( // see RULE2
        @(posedge core_clk) disable iff (!reset_n)
        fire_a && k != 8'h00 |=> hold_v == $past(hold_v) || $past(accept))
        else $error("input consumed mid burst");
    AST_REAL_RATE: assert property ( // see RULE7
        @(posedge core_clk) disable iff (!reset_n)
        fire_a && !cplx |=> slot == SLOT_I)
        else $error("real mode left the I slot");
    AST_CPLX_RATE: assert property ( // see RULE6
        @(posedge core_clk) disable iff (!reset_n)
        fire_a && cplx |=> slot == SLOT_Q ##0 !fire_a)
        else $error("complex oscillator advanced twice");
    AST_Q_FOLLOWS: assert property ( // see RULE5
        @(posedge core_clk) disable iff (!reset_n)
        fire_b |-> push_word.is_q && push_word.data == q_held)
        else $error("Q word not sent after I");
    AST_ACC_STEP: assert property ( // see RULE13
        @(posedge core_clk) disable iff (!reset_n)
        fire_a && !clear_phase |=> acc == $past(acc) + $past(freq))
        else $error("accumulator step wrong");
    AST_PHASE_CLEAR: assert property ( // see RULE15
        @(posedge core_clk) disable iff (!reset_n)
        clear_phase |=> acc == 32'h0)
        else $error("phase not cleared on sync");
    AST_NO_PDITH: assert property ( // see RULE10
        @(posedge core_clk) disable iff (!reset_n)
        !ctrl[CTRL_PDITH] |-> phase_full[PHASE_LSB-1:0] == acc[PHASE_LSB-1:0])
        else $error("phase disturbed without dither");

    COV_REAL: cover property (@(posedge core_clk) fire_a && !cplx);
    COV_CPLX: cover property (@(posedge core_clk) fire_a && cplx ##1 fire_b);
    COV_SYNC: cover property (@(posedge core_clk) clear_phase);
    COV_INTERP: cover property (@(posedge core_clk)
        fire_a && k == factor && factor > 8'h02);
endmodule
`default_nettype wire
